// File: logic/tpc_ctrl.sv
/*
 * Conversion and power-mode control of the temperature converter.
 * Assumes the serial engine on mclk supplies transaction events, the
 * register file supplies the mode bits, and the analog converter
 * answers each start with a done pulse and a result.
 */
`timescale 1ns/100ps
`include "tpc_defs.svh"

module tpc_ctrl #(
    parameter int PERIOD_CYC = `TPC_PERIOD_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Mode bits from the configuration registers
    input wire logic shutdown_bit,
    input wire logic pin_mode_bit,
    input wire logic defaults_ok,
    // Serial engine events
    input wire logic bus_write,
    input wire logic bus_read_active,
    input wire logic bus_stop,
    input wire logic [2:0] addr_pins,
    // Start pin from outside
    input wire logic conversion_start_pin,
    // Analog converter
    input wire logic adc_done,
    input wire tpc_pkg::tpc_result_t adc_result,
    output logic adc_start,
    output logic adc_abort,
    output logic track_hold,
    // Status and data
    output logic full_powerdown,
    output logic partial_powerdown,
    output logic oti_reset,
    output tpc_pkg::tpc_addr_t bus_address,
    output tpc_pkg::tpc_result_t temp_result
);
    import tpc_pkg::*;

    tpc_state_e state;
    tpc_state_e next_state;
    tpc_tmr_if tl ();
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_rise;
    logic pin_fall;
    logic active_mode;
    logic wake_req;
    logic read_seen;
    logic shut_prev;
    logic [`TPC_PER_W-1:0] per_cnt;
    logic per_due;
    logic go;
    logic start_now;
    logic abort;
    tpc_result_t result;

    // ------------------------------------------------------------
    // Start pin synchroniser and edges
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= conversion_start_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign pin_rise = pin_s2 & ~pin_s3;
    assign pin_fall = ~pin_s2 & pin_s3;

    // ------------------------------------------------------------
    // Power-up timer
    // ------------------------------------------------------------
    tpc_timer u_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tl(tl.tmr)
    );

    // Only a rising edge seen while idle arms the timer
    assign tl.start = pin_mode_bit & defaults_ok & pin_rise & (state == TPC_IDLE);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign active_mode = ~shutdown_bit & ~pin_mode_bit;

    // ------------------------------------------------------------
    // Periodic schedule in active mode
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            per_cnt <= '0;
        end else if (!active_mode || start_now) begin
            // Restart on the start decision itself, so the period is exactly PERIOD_CYC
            per_cnt <= '0;
        end else if (!per_due) begin
            per_cnt <= per_cnt + `TPC_PER_W'(1);
        end
    end

    assign per_due = (per_cnt == `TPC_PER_W'(PERIOD_CYC - 1));

    // ------------------------------------------------------------
    // Wake request from a write during full power-down
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wake_req <= 1'b0;
        end else if (bus_write && shutdown_bit && !pin_mode_bit) begin
            wake_req <= 1'b1;
        end else if (adc_start || !shutdown_bit) begin
            wake_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read seen in active mode: convert on the stop
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            read_seen <= 1'b0;
        end else if (bus_read_active && active_mode) begin
            read_seen <= 1'b1;
        end else if (bus_stop || !active_mode) begin
            read_seen <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Conversion start and abort decisions
    // ------------------------------------------------------------
    always_comb begin
        go = 1'b0;
        if (defaults_ok && state == TPC_IDLE && !bus_read_active) begin
            if (active_mode) begin
                go = per_due | (read_seen & bus_stop);
            end else if (shutdown_bit && !pin_mode_bit) begin
                go = wake_req;
            end
        end
    end

    assign abort = (state == TPC_CONVERT) & bus_read_active & ~adc_done;

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            TPC_IDLE: begin
                if (tl.start) begin
                    next_state = TPC_POWERUP;
                end else if (go) begin
                    next_state = TPC_CONVERT;
                end
            end
            TPC_POWERUP: begin
                if (tl.expired) begin
                    next_state = pin_s2 ? TPC_WAITFALL : TPC_CONVERT;
                end
            end
            TPC_WAITFALL: begin
                if (pin_fall) begin
                    next_state = TPC_CONVERT;
                end
            end
            TPC_CONVERT: begin
                if (adc_done || abort) begin
                    next_state = TPC_IDLE;
                end
            end
        endcase
        if (!defaults_ok) begin
            next_state = TPC_IDLE;
        end
    end

    assign start_now = (state != TPC_CONVERT) & (next_state == TPC_CONVERT);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= TPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Converter strobes
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            adc_start <= 1'b0;
            adc_abort <= 1'b0;
            track_hold <= 1'b0;
        end else begin
            adc_start <= start_now;
            adc_abort <= abort;
            track_hold <= (next_state == TPC_CONVERT);
        end
    end

    // ------------------------------------------------------------
    // Result keeping; aborted conversions leave the last result
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result <= `TPC_RESULT_RST;
        end else if (state == TPC_CONVERT && adc_done && !abort) begin
            result <= adc_result;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            temp_result <= `TPC_RESULT_RST;
        end else begin
            temp_result <= defaults_ok ? result : `TPC_STUCK_RESULT;
        end
    end

    // ------------------------------------------------------------
    // Power state, indicator reset and address
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            full_powerdown <= 1'b0;
            partial_powerdown <= 1'b0;
            shut_prev <= 1'b0;
            oti_reset <= 1'b0;
        end else begin
            full_powerdown <= (next_state == TPC_IDLE) & (~active_mode | ~defaults_ok);
            partial_powerdown <= (next_state == TPC_IDLE) & active_mode & defaults_ok;
            shut_prev <= shutdown_bit;
            oti_reset <= shutdown_bit & ~shut_prev;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bus_address <= {`TPC_ADDR_BASE, 3'h0};
        end else begin
            bus_address <= {`TPC_ADDR_BASE, addr_pins};
        end
    end

endmodule : tpc_ctrl

// File: inc/tpc_defs.svh
/*
 * Constants of the temperature converter power and conversion control.
 * Assumes a 100 MHz system clock; included by the package and design files.
 */
// What this block does
// - Shutdown bit set enters full power-down
// - Serial write wakes device from full power-down
// - Woken device converts once, then powers down
// - Result stays readable while fully powered down
// - Read overlapping a conversion aborts it
// - Second config register MSB selects pin mode
// - Pin mode converts only on start pin pulses
// - Start pin rising edge begins 4 us power-up
// - Long pulse: convert and hold on falling edge
// - Short pulse: convert 4 us after rising edge
// - Pin conversion done with pin low: power down
// - Failed power-on load: no conversions, constant result
// - Address fixed upper bits, three user low bits
// - Shutdown clear: convert every 400 us
// - Active read aborts, restarts conversion on stop
// - Entering shutdown resets the over-temperature indicator
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define TPC_CLK_MHZ 100
`define TPC_POWERUP_NS 4000
`define TPC_POWERUP_CYC ((`TPC_POWERUP_NS * `TPC_CLK_MHZ + 999) / 1000)
`define TPC_PERIOD_US 400
`define TPC_PERIOD_CYC (`TPC_PERIOD_US * `TPC_CLK_MHZ)
`define TPC_TMR_W 9
`define TPC_PER_W 16

// ------------------------------------------------------------
// Data, address and default values
// ------------------------------------------------------------
`define TPC_RES_W 10
`define TPC_ADDR_BASE 4'h9
`define TPC_STUCK_RESULT 10'h000
`define TPC_RESULT_RST 10'h000
`define TPC_CFG_DEFAULT 8'h00
`define TPC_CFG2_DEFAULT 8'h00
`define TPC_HYST_DEFAULT 16'h4B00
`define TPC_OTI_DEFAULT 16'h5500

`endif

// File: inc/tpc_pkg.sv
/*
 * Types of the temperature converter control.
 * Assumes tpc_defs.svh on the include path.
 */
`include "tpc_defs.svh"

package tpc_pkg;

    typedef enum logic [1:0] {
        TPC_IDLE,
        TPC_POWERUP,
        TPC_WAITFALL,
        TPC_CONVERT
    } tpc_state_e;

    typedef logic [`TPC_RES_W-1:0] tpc_result_t;
    typedef logic [6:0] tpc_addr_t;

endpackage : tpc_pkg

// File: inc/tpc_tmr_if.sv
/*
 * Link between the controller and its power-up timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps

interface tpc_tmr_if;
    logic start;
    logic expired;

    modport ctrl (output start, input expired);
    modport tmr (input start, output expired);
endinterface : tpc_tmr_if

// File: logic/tpc_timer.sv
/*
 * Power-up timer: a start pulse arms it, one expiry pulse follows.
 * Assumes mclk at 100 MHz and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "tpc_defs.svh"

module tpc_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Controller link
    tpc_tmr_if.tmr tl
);
    import tpc_pkg::*;

    logic [`TPC_TMR_W-1:0] count;
    logic running;
    logic expired;

    // ------------------------------------------------------------
    // Count from the rising edge
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (tl.start) begin
                count <= '0;
                running <= 1'b1;
            end else if (running) begin
                if (count == `TPC_TMR_W'(`TPC_POWERUP_CYC - 2)) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
                count <= count + `TPC_TMR_W'(1);
            end
        end
    end

    assign tl.expired = expired;

endmodule : tpc_timer

// File: tb/tpc_ctrl_assertions.sv
/*
 * Port checker of the conversion control.
 * Assumes mclk and a synchronous active-high sys_rst.
 */
`timescale 1ns/100ps

module tpc_ctrl_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Watched ports
    input wire logic shutdown_bit,
    input wire logic pin_mode_bit,
    input wire logic defaults_ok,
    input wire logic bus_write,
    input wire logic bus_read_active,
    input wire logic [2:0] addr_pins,
    input wire logic conversion_start_pin,
    input wire logic adc_done,
    input wire logic adc_start,
    input wire logic adc_abort,
    input wire logic track_hold,
    input wire logic full_powerdown,
    input wire logic oti_reset,
    input wire tpc_pkg::tpc_addr_t bus_address,
    input wire tpc_pkg::tpc_result_t temp_result
);
    import tpc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_addr_fixed: assert property (!$past(sys_rst) |-> bus_address == {4'h9, $past(addr_pins)})
        else $error("bus address wrong");
    a_oti_pulse: assert property ($rose(shutdown_bit) |=> oti_reset ##1 !oti_reset)
        else $error("indicator reset pulse wrong");
    a_no_start: assert property (!defaults_ok [*2] |-> !adc_start)
        else $error("start without defaults");
    a_stuck_out: assert property (!defaults_ok [*3] |-> temp_result == 10'h000)
        else $error("result not constant");
    a_read_abort: assert property (bus_read_active && track_hold && !adc_done |=> adc_abort && !track_hold)
        else $error("read did not abort");
    a_wake_start: assert property (bus_write && shutdown_bit && !pin_mode_bit && defaults_ok && full_powerdown
        ##1 !bus_read_active |=> adc_start)
        else $error("write did not wake");
    a_back_down: assert property (adc_done && shutdown_bit && !pin_mode_bit && defaults_ok
        |-> ##[1:2] full_powerdown)
        else $error("no return to power-down");
    a_pin_down: assert property (adc_done && pin_mode_bit && !conversion_start_pin |-> ##[1:2] full_powerdown)
        else $error("pin conversion did not power down");
    a_pin_timer: assert property ($rose(conversion_start_pin) && pin_mode_bit && !track_hold && defaults_ok
        ##1 !conversion_start_pin |-> ##[398:406] adc_start)
        else $error("short pulse start late");
endmodule : tpc_ctrl_chk

bind tpc_ctrl tpc_ctrl_chk u_chk (.*);

// File: tb/tpc_adc_model.sv
/*
 * Converter model: a done pulse LAT cycles after each start.
 * Assumes the control's clock; an abort drops the conversion.
 */
`timescale 1ns/100ps

module tpc_adc_model #(
    parameter int LAT = 20
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control side
    input wire logic adc_start,
    input wire logic adc_abort,
    input wire tpc_pkg::tpc_result_t res_in,
    output logic adc_done,
    output tpc_pkg::tpc_result_t adc_result
);
    import tpc_pkg::*;
    int cnt;

    // Result is only valid with done, so it toggles otherwise
    always_ff @(posedge mclk) begin
        adc_done <= 1'b0;
        adc_result <= ~adc_result;
        if (sys_rst || adc_abort) begin
            cnt <= 0;
            adc_result <= 10'h155;
        end else if (adc_start) begin
            cnt <= LAT;
        end else if (cnt == 1) begin
            cnt <= 0;
            adc_done <= 1'b1;
            adc_result <= res_in;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : tpc_adc_model

// File: tb/tb_top.sv
/*
 * Scenario bench of the conversion control.
 * Assumes the converter model and the bound checker.
 */
`timescale 1ns/100ps

module tb_top;
    import tpc_pkg::*;
    logic mclk, sys_rst, shutdown_bit, pin_mode_bit, defaults_ok, bus_write, bus_read_active, bus_stop;
    logic conversion_start_pin, adc_done, adc_start, adc_abort, track_hold, full_powerdown;
    logic partial_powerdown, oti_reset;
    logic [2:0] addr_pins;
    tpc_result_t adc_result, temp_result, res_in;
    tpc_addr_t bus_address;
    int bad_count = 0, n_tests = 0, starts = 0, n, s0;

    tpc_ctrl #(.PERIOD_CYC(200)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .shutdown_bit(shutdown_bit),
        .pin_mode_bit(pin_mode_bit), .defaults_ok(defaults_ok), .bus_write(bus_write),
        .bus_read_active(bus_read_active), .bus_stop(bus_stop), .addr_pins(addr_pins),
        .conversion_start_pin(conversion_start_pin), .adc_done(adc_done), .adc_result(adc_result),
        .adc_start(adc_start), .adc_abort(adc_abort), .track_hold(track_hold),
        .full_powerdown(full_powerdown), .partial_powerdown(partial_powerdown), .oti_reset(oti_reset),
        .bus_address(bus_address), .temp_result(temp_result));
    tpc_adc_model u_adc (.mclk(mclk), .sys_rst(sys_rst), .adc_start(adc_start), .adc_abort(adc_abort),
        .res_in(res_in), .adc_done(adc_done), .adc_result(adc_result));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (adc_start === 1'b1) starts++;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    // Bounded wait for a start pulse, n cycles taken
    task automatic wait_start(input int lim);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (adc_start !== 1'b1 && n < lim);
        if (adc_start !== 1'b1) begin
            bad_count++;
            $display("BAD %0t no start within limit", $time);
            give_verdict();
        end
    endtask : wait_start
    task automatic idle_starts(input int cyc, input int exp);
        s0 = starts;
        repeat (cyc) @(negedge mclk);
        check(16'(starts - s0), 16'(exp));
    endtask : idle_starts

    task automatic t_addr();
        for (int i = 0; i < 8; i++) begin
            addr_pins = 3'(i);
            repeat (2) @(negedge mclk);
            check(16'(bus_address), 16'({4'h9, 3'(i)}));
        end
    endtask : t_addr
    task automatic t_active();
        res_in = 10'h2A5;
        wait_start(1000);
        wait_start(1000);
        check(16'(n), 16'h00C8);
        repeat (25) @(negedge mclk);
        check(16'(temp_result), 16'h02A5);
        check(16'(partial_powerdown), 16'h0001);
        res_in = 10'h0F0;
        wait_start(300);
        bus_read_active = 1'b1;
        @(negedge mclk);
        bus_read_active = 1'b0;
        check(16'({adc_abort, track_hold}), 16'h0002);
        repeat (25) @(negedge mclk);
        check(16'(temp_result), 16'h02A5);
        bus_stop = 1'b1;
        @(negedge mclk);
        bus_stop = 1'b0;
        check(16'(adc_start), 16'h0001);
        repeat (25) @(negedge mclk);
        check(16'(temp_result), 16'h00F0);
    endtask : t_active
    task automatic t_baddef();
        defaults_ok = 1'b0;
        idle_starts(500, 0);
        check(16'(temp_result), 16'h0000);
        res_in = 10'h1E1;
        defaults_ok = 1'b1;
        wait_start(500);
        repeat (25) @(negedge mclk);
        check(16'(temp_result), 16'h01E1);
    endtask : t_baddef
    task automatic t_shutdown();
        shutdown_bit = 1'b1;
        @(negedge mclk);
        check(16'(oti_reset), 16'h0001);
        idle_starts(300, 0);
        check(16'(full_powerdown), 16'h0001);
        res_in = 10'h3C3;
        bus_write = 1'b1;
        @(negedge mclk);
        bus_write = 1'b0;
        s0 = starts;
        wait_start(5);
        idle_starts(300, 1);
        check(16'({full_powerdown, temp_result}), 16'h07C3);
    endtask : t_shutdown
    task automatic t_pin();
        shutdown_bit = 1'b0;
        pin_mode_bit = 1'b1;
        idle_starts(300, 0);
        conversion_start_pin = 1'b1;
        @(negedge mclk);
        conversion_start_pin = 1'b0;
        wait_start(500);
        check(16'(n >= 398 && n <= 406), 16'h0001);
        conversion_start_pin = 1'b1;
        @(negedge mclk);
        conversion_start_pin = 1'b0;
        idle_starts(600, 0);
        check(16'(full_powerdown), 16'h0001);
        conversion_start_pin = 1'b1;
        repeat (600) @(negedge mclk);
        check(16'(track_hold), 16'h0000);
        conversion_start_pin = 1'b0;
        wait_start(20);
        repeat (30) @(negedge mclk);
        check(16'(full_powerdown), 16'h0001);
    endtask : t_pin

    initial begin
        {sys_rst, defaults_ok} = 2'b11;
        {shutdown_bit, pin_mode_bit, bus_write, bus_read_active, bus_stop, conversion_start_pin} = 6'h00;
        {addr_pins, res_in} = 13'h0000;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        t_addr();
        t_active();
        t_baddef();
        t_shutdown();
        t_pin();
        give_verdict();
    end
endmodule : tb_top
